// *** gpts_pkg.sv ***
// Package: register map, field layout and sense codes of the GPIO toggle/sense block
package gpts_pkg;

	// ********************************************************************
	// Register offsets
	// ********************************************************************
	localparam logic [4:0] OFF_DRIVE_TOGGLE_MASK  = 5'h07;
	localparam logic [4:0] OFF_PIN_INPUT_VALUE    = 5'h08;
	localparam logic [4:0] OFF_PIN_FLAG_REGISTER  = 5'h09;
	localparam logic [4:0] OFF_PORT_SETTINGS      = 5'h0A;
	localparam logic [4:0] OFF_MULTI_PIN_TEMPLATE = 5'h0B;
	localparam logic [4:0] OFF_COPY_MASK          = 5'h0C;
	localparam logic [4:0] OFF_PER_PIN_BASE       = 5'h10;
	localparam logic [4:0] OFF_DRIVE_LEVEL        = 5'h04;
	localparam logic [4:0] OFF_DIRECTION          = 5'h00;

	// ********************************************************************
	// Field positions and masks
	// ********************************************************************
	localparam int          INVERT_IO_ENABLE_BIT     = 7;
	localparam int          THRESHOLD_SELECT_BIT     = 6;
	localparam int          PULL_RESISTOR_ENABLE_BIT = 3;
	localparam int          SLEW_LIMIT_ENABLE_BIT    = 0;
	localparam logic [7:0]  PIN_SETTINGS_MASK        = 8'hCF;
	localparam logic [7:0]  PORT_SETTINGS_MASK       = 8'h01;

	// ********************************************************************
	// Reset values
	// ********************************************************************
	localparam logic [7:0]  RESET_BYTE = 8'h00;

	// ********************************************************************
	// Sense configuration codes
	// ********************************************************************
	localparam logic [2:0]  SENSE_OFF_BUFFER_ON = 3'h0;
	localparam logic [2:0]  ANY_EDGE_SENSE      = 3'h1;
	localparam logic [2:0]  RISE_SENSE          = 3'h2;
	localparam logic [2:0]  FALL_SENSE          = 3'h3;
	localparam logic [2:0]  BUFFER_OFF          = 3'h4;
	localparam logic [2:0]  LOW_LEVEL_SENSE     = 3'h5;

endpackage

// *** gpts_port.sv ***
// Module: 8-pin GPIO port with toggle, input sampling, sense flags and multi-pin configuration
`timescale 1ns/1ps

// Notes on behaviour
// - Toggle mask ones invert drive level bits
// - Toggle mask reads return drive level
// - Input value shows sampled pin level
// - Input value write ones invert drive level
// - Buffer off holds input bit unchanged
// - Flag set when pin matches sense condition
// - Writing one clears a flag
// - Port settings bit 0 is slew limit
// - Invert bit flips input and output
// - Threshold select bit picks input threshold
// - Pull-up only while pin is input-only
// - Codes 1,2,3: both, rising, falling edges
// - Code 0 no flag, 4 buffer off
// - Code 5 flags and retriggers while low
// - Template is one shared copy
// - Copy mask ones load template into pins
// - Copy mask reads return zero
// - All selected pins update in one cycle
// - Per-pin settings at 0x10 plus n
module gpts_port #(
	parameter int PINS = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [4:0]       addr,
	input  wire logic [7:0]       wdata,
	input  wire logic             wr_en,
	input  wire logic             rd_en,
	output logic      [7:0]       rdata,
	input  wire logic [PINS-1:0]  pin_in_schmitt,
	input  wire logic [PINS-1:0]  pin_in_ttl,
	output logic      [PINS-1:0]  pin_out,
	output logic      [PINS-1:0]  pin_oe,
	output logic      [PINS-1:0]  pin_pullup,
	output logic      [PINS-1:0]  pin_ttl_select,
	output logic                  slew_limit,
	output logic                  irq
);

	// ********************************************************************
	// State
	// ********************************************************************
	logic [PINS-1:0] direction_q;
	logic [PINS-1:0] drive_level_q;
	logic [PINS-1:0] input_value_q;
	logic [PINS-1:0] prev_level_q;
	logic [PINS-1:0] flags_q;
	logic [7:0]      port_settings_q;
	logic [7:0]      template_q;
	logic [7:0]      pin_cfg_q [PINS];
	logic [PINS-1:0] level_now;
	logic [PINS-1:0] buffer_on;
	logic [PINS-1:0] hit;
	logic [7:0]      rdata_d;

	// Next values and decodes
	logic [PINS-1:0] flag_set;
	logic [PINS-1:0] flag_clr;
	logic [PINS-1:0] drive_level_d;
	logic [7:0]      pin_cfg_d [PINS];
	logic            rd_per_pin;
	logic [7:0]      pin_cfg_rd;

	// Write hit decode
	function automatic logic wr_at(input logic [4:0] off);
		return wr_en && (addr == off);
	endfunction

	// ********************************************************************
	// Input path: threshold choice, inversion, buffer enable, sense match
	// ********************************************************************
	// Sense decode; reserved codes never flag
	function automatic logic sense_match(
		input logic [2:0] code,
		input logic       now,
		input logic       prev
	);
		unique case (code)
			gpts_pkg::ANY_EDGE_SENSE:  return now != prev;
			gpts_pkg::RISE_SENSE:      return now & ~prev;
			gpts_pkg::FALL_SENSE:      return ~now & prev;
			gpts_pkg::LOW_LEVEL_SENSE: return ~now;
			default:                   return 1'b0;
		endcase
	endfunction

	// Inversion is applied before sampling, so sense sees the inverted level
	always_comb
	begin
		for (int n = 0; n < PINS; n++)
			level_now[n] = (pin_cfg_q[n][gpts_pkg::THRESHOLD_SELECT_BIT] ? pin_in_ttl[n] : pin_in_schmitt[n])
				^ pin_cfg_q[n][gpts_pkg::INVERT_IO_ENABLE_BIT];
	end

	always_comb
	begin
		for (int n = 0; n < PINS; n++)
			buffer_on[n] = (pin_cfg_q[n][2:0] != gpts_pkg::BUFFER_OFF);
	end

	always_comb
	begin
		for (int n = 0; n < PINS; n++)
			hit[n] = sense_match(pin_cfg_q[n][2:0], level_now[n], prev_level_q[n]);
	end

	// ********************************************************************
	// Input sampling
	// ********************************************************************
	// Both samples freeze together while a buffer is off, so edge
	// detection resumes from the last seen level when it is turned on
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			input_value_q <= '0;
		else
		begin
			for (int n = 0; n < PINS; n++)
			begin
				if (buffer_on[n])
					input_value_q[n] <= level_now[n];
			end
		end
	end

	// Previous level for edge sense
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			prev_level_q <= '0;
		else
		begin
			for (int n = 0; n < PINS; n++)
			begin
				if (buffer_on[n])
					prev_level_q[n] <= level_now[n];
			end
		end
	end

	// ********************************************************************
	// Flags: a hit in the clearing cycle wins
	// ********************************************************************
	// A level-sensed pin that stays low sets its flag every cycle, so a
	// clear only sticks once the pin has gone high again
	always_comb
	begin
		flag_set = '0;
		flag_clr = '0;
		for (int n = 0; n < PINS; n++)
		begin
			flag_set[n] = buffer_on[n] & hit[n];
			flag_clr[n] = wr_at(gpts_pkg::OFF_PIN_FLAG_REGISTER) & wdata[n];
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			flags_q <= '0;
		else
			flags_q <= flag_set | (flags_q & ~flag_clr);
	end

	// Request follows the flags one cycle later

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |flags_q;
	end

	// ********************************************************************
	// Drive level and direction
	// ********************************************************************
	// Toggle through either offset saves software a read-modify-write
	always_comb
	begin
		drive_level_d = drive_level_q;
		if (wr_at(gpts_pkg::OFF_DRIVE_LEVEL))
			drive_level_d = wdata[PINS-1:0];
		else if (wr_at(gpts_pkg::OFF_DRIVE_TOGGLE_MASK))
			drive_level_d = drive_level_q ^ wdata[PINS-1:0];
		else if (wr_at(gpts_pkg::OFF_PIN_INPUT_VALUE))
			drive_level_d = drive_level_q ^ wdata[PINS-1:0];
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			drive_level_q <= '0;
		else
			drive_level_q <= drive_level_d;
	end

	// Direction: a set bit enables the pin driver

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			direction_q <= '0;
		else if (wr_at(gpts_pkg::OFF_DIRECTION))
			direction_q <= wdata[PINS-1:0];
	end

	// ********************************************************************
	// Settings: port, shared template, per-pin
	// ********************************************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			port_settings_q <= gpts_pkg::RESET_BYTE;
		else if (wr_at(gpts_pkg::OFF_PORT_SETTINGS))
			port_settings_q <= wdata & gpts_pkg::PORT_SETTINGS_MASK;
	end

	// One template register per port instance serves all its pins
	// Loading it alone changes no pin; only the copy mask applies it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			template_q <= gpts_pkg::RESET_BYTE;
		else if (wr_at(gpts_pkg::OFF_MULTI_PIN_TEMPLATE))
			template_q <= wdata & gpts_pkg::PIN_SETTINGS_MASK;
	end

	// Copy and direct write select different offsets, so they never meet
	always_comb
	begin
		for (int n = 0; n < PINS; n++)
		begin
			pin_cfg_d[n] = pin_cfg_q[n];
			if (wr_at(gpts_pkg::OFF_COPY_MASK) && wdata[n])
				pin_cfg_d[n] = template_q;
			else if (wr_at(gpts_pkg::OFF_PER_PIN_BASE + 5'(n)))
				pin_cfg_d[n] = wdata & gpts_pkg::PIN_SETTINGS_MASK;
		end
	end

	// All selected pins load on the same edge
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int n = 0; n < PINS; n++)
				pin_cfg_q[n] <= gpts_pkg::RESET_BYTE;
		end
		else
		begin
			for (int n = 0; n < PINS; n++)
				pin_cfg_q[n] <= pin_cfg_d[n];
		end
	end

	// ********************************************************************
	// Pin drive outputs
	// ********************************************************************
	// Every pin-facing signal is registered, one cycle behind its register
	// Inversion sits after the drive level, so reads of it stay uninverted
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pin_out <= '0;
		else
		begin
			for (int n = 0; n < PINS; n++)
				pin_out[n] <= drive_level_q[n] ^ pin_cfg_q[n][gpts_pkg::INVERT_IO_ENABLE_BIT];
		end
	end

	// Driver on where direction is set
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pin_oe <= '0;
		else
			pin_oe <= direction_q;
	end

	// Pull-up masked on driven pins so it never fights the driver
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pin_pullup <= '0;
		else
		begin
			for (int n = 0; n < PINS; n++)
				pin_pullup[n] <= pin_cfg_q[n][gpts_pkg::PULL_RESISTOR_ENABLE_BIT] & ~direction_q[n];
		end
	end

	// Receiver threshold choice for the pad
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pin_ttl_select <= '0;
		else
		begin
			for (int n = 0; n < PINS; n++)
				pin_ttl_select[n] <= pin_cfg_q[n][gpts_pkg::THRESHOLD_SELECT_BIT];
		end
	end

	// One slew limit for the whole port
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			slew_limit <= 1'b0;
		else
			slew_limit <= port_settings_q[gpts_pkg::SLEW_LIMIT_ENABLE_BIT];
	end

	// ********************************************************************
	// Read path
	// ********************************************************************
	// Per-pin window is decoded apart from the fixed offsets
	always_comb
	begin
		rd_per_pin = (addr >= gpts_pkg::OFF_PER_PIN_BASE) && (addr < gpts_pkg::OFF_PER_PIN_BASE + 5'(PINS));
		pin_cfg_rd = pin_cfg_q[3'(addr - gpts_pkg::OFF_PER_PIN_BASE)];
	end

	// Unmapped offsets and the write-only copy mask read as zero
	always_comb
	begin
		rdata_d = 8'h00;
		if (rd_per_pin)
			rdata_d = pin_cfg_rd;
		else
		begin
			unique case (addr)
				gpts_pkg::OFF_DIRECTION:          rdata_d = 8'(direction_q);
				gpts_pkg::OFF_DRIVE_LEVEL:        rdata_d = 8'(drive_level_q);
				gpts_pkg::OFF_DRIVE_TOGGLE_MASK:  rdata_d = 8'(drive_level_q);
				gpts_pkg::OFF_PIN_INPUT_VALUE:    rdata_d = 8'(input_value_q);
				gpts_pkg::OFF_PIN_FLAG_REGISTER:  rdata_d = 8'(flags_q);
				gpts_pkg::OFF_PORT_SETTINGS:      rdata_d = port_settings_q;
				gpts_pkg::OFF_MULTI_PIN_TEMPLATE: rdata_d = template_q;
				gpts_pkg::OFF_COPY_MASK:          rdata_d = 8'h00;
				default:                          rdata_d = 8'h00;
			endcase
		end
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata <= 8'h00;
		else if (rd_en)
			rdata <= rdata_d;
		else
			rdata <= 8'h00;
	end

endmodule

// *** gpts_pins.sv ***
// Partner model: pin levels as seen through both input receivers
`timescale 1ns/1ps
module gpts_pins (
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] ext_level,
	input  wire logic [7:0] mid_level,
	output logic      [7:0] pin_in_schmitt,
	output logic      [7:0] pin_in_ttl
);
	logic [7:0] lvl;
	assign lvl = (pin_oe & pin_out) | (~pin_oe & ext_level);
	// A mid level sits between thresholds: low to Schmitt, high to TTL
	assign pin_in_schmitt = lvl & ~mid_level;
	assign pin_in_ttl     = lvl | mid_level;
endmodule

// *** gpts_port_checker.sv ***
// Checker: port-level assertions of the GPIO toggle/sense block
`timescale 1ns/1ps
module gpts_port_checker #(
	parameter int PINS = 8
) (
	input wire logic            clk,
	input wire logic            rst,
	input wire logic [4:0]      addr,
	input wire logic [7:0]      wdata,
	input wire logic            wr_en,
	input wire logic            rd_en,
	input wire logic [7:0]      rdata,
	input wire logic [PINS-1:0] pin_out,
	input wire logic [PINS-1:0] pin_oe,
	input wire logic [PINS-1:0] pin_pullup,
	input wire logic            slew_limit,
	input wire logic            irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_RDATA_IDLE: assert property (!rd_en |=> rdata == 8'h00) else $error("rdata not idle zero");
	AST_COPY_READ_ZERO: assert property (rd_en && addr == 5'h0C |=> rdata == 8'h00)
		else $error("copy mask read not zero");
	AST_TOGGLE_OUT: assert property (wr_en && (addr == 5'h07 || addr == 5'h08) ##1 !wr_en
		|=> pin_out == ($past(pin_out) ^ $past(wdata, 2))) else $error("toggle not applied");
	AST_IRQ_FLAGS: assert property (rd_en && addr == 5'h09 |=> irq == (|rdata))
		else $error("irq differs from flags");
	AST_SLEW: assert property (wr_en && addr == 5'h0A |-> ##2 slew_limit == $past(wdata[0], 2))
		else $error("slew limit wrong");
	AST_PULLUP_INPUT_ONLY: assert property ((pin_pullup & pin_oe) == {PINS{1'b0}})
		else $error("pull-up on driven pin");
	AST_UNMAPPED: assert property (rd_en && addr inside {[5'h0D:5'h0F], [5'h18:5'h1F]} |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_RSV_BITS: assert property (rd_en && (addr == 5'h0B || addr[4:3] == 2'b10) |=> rdata[5:4] == 2'b00)
		else $error("reserved bits set");
	cover property (irq);
	cover property (wr_en && addr == 5'h0C);
	cover property (slew_limit);
endmodule
bind gpts_port gpts_port_checker #(.PINS(PINS)) u_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
	.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pin_out(pin_out), .pin_oe(pin_oe),
	.pin_pullup(pin_pullup), .slew_limit(slew_limit), .irq(irq));

// *** testbench.sv ***
// Testbench: register, pin and sense scenarios of the GPIO toggle/sense block
`timescale 1ns/1ps
module testbench;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [4:0] addr = 5'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr_en = 1'b0;
	logic       rd_en = 1'b0;
	logic [7:0] ext_level = 8'h00;
	logic [7:0] mid_level = 8'h00;
	logic [7:0] rdata, pin_out, pin_oe, pin_pullup, pin_ttl_select, sch, ttl;
	logic       slew_limit, irq;
	int         err_count = 0;
	int         comparisons = 0;
	always #10 clk = ~clk;
	gpts_port dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .pin_in_schmitt(sch), .pin_in_ttl(ttl), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .pin_ttl_select(pin_ttl_select), .slew_limit(slew_limit), .irq(irq));
	gpts_pins pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .mid_level(mid_level),
		.pin_in_schmitt(sch), .pin_in_ttl(ttl));
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task rd(input logic [4:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 chk($sformatf("reg %h", a), rdata, exp);
	endtask
	task pin(input logic v);
		@(posedge clk);
		ext_level <= {7'h00, v};
		repeat (3) @(posedge clk);
	endtask
	task test_done;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task t_regs;
		for (int a = 7; a < 13; a++)
			rd(a[4:0], 8'h00);
		wr(5'h07, 8'hA5);
		rd(5'h07, 8'hA5);
		wr(5'h08, 8'h0F);
		rd(5'h07, 8'hAA);
		wr(5'h07, 8'h00);
		rd(5'h07, 8'hAA);
		chk("pin_out", pin_out, 8'hAA);
		wr(5'h0A, 8'hFF);
		rd(5'h0A, 8'h01);
		chk("slew", {7'h00, slew_limit}, 8'h01);
		wr(5'h0D, 8'hFF);
		rd(5'h0D, 8'h00);
	endtask
	task t_sense;
		logic [5:0] fall_t, rise_t;
		fall_t = 6'b101010;
		rise_t = 6'b100110;
		for (int c = 0; c < 6; c++)
		begin
			wr(5'h10, {5'h00, c[2:0]});
			pin(1'b1);
			wr(5'h09, 8'hFF);
			pin(1'b0);
			rd(5'h09, {7'h00, fall_t[c]});
			chk("irq", {7'h00, irq}, {7'h00, fall_t[c]});
			rd(5'h08, {7'h00, c == 4});
			wr(5'h09, 8'h01);
			rd(5'h09, {7'h00, c == 5});
			pin(1'b1);
			rd(5'h09, {7'h00, rise_t[c]});
			wr(5'h09, 8'h01);
			rd(5'h09, 8'h00);
		end
		wr(5'h10, 8'h40);
		pin(1'b0);
		@(posedge clk);
		mid_level <= 8'h01;
		rd(5'h08, 8'h01);
		chk("ttl_sel", pin_ttl_select, 8'h01);
		wr(5'h10, 8'h00);
		rd(5'h08, 8'h00);
	endtask
	task t_copy;
		wr(5'h0B, 8'hB9);
		rd(5'h0B, 8'h89);
		wr(5'h0C, 8'h81);
		rd(5'h0C, 8'h00);
		rd(5'h10, 8'h89);
		rd(5'h17, 8'h89);
		rd(5'h11, 8'h00);
		rd(5'h08, 8'h81);
		chk("pin_out", pin_out, 8'h2B);
		chk("pullup", pin_pullup, 8'h81);
		wr(5'h00, 8'h01);
		repeat (2) @(posedge clk);
		chk("pullup", pin_pullup, 8'h80);
		chk("oe", pin_oe, 8'h01);
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_sense;
		t_copy;
		test_done;
	end
	initial
	begin
		#1000000;
		err_count++;
		test_done;
	end
endmodule
